// ===== hw/tascr_pkg.sv
// tascr_pkg: offsets, field positions, reset values and timing for the
// touch converter sequence/limit register bank.
// assumes a single 20 MHz core clock shared by the whole unit.
package tascr_pkg;
    // register offsets (word addresses on the host register port)
    localparam logic [3:0] OFS_SEQ_CFG    = 4'h3;
    localparam logic [3:0] OFS_AUX_HI     = 4'h4;
    localparam logic [3:0] OFS_AUX_LO     = 4'h5;
    localparam logic [3:0] OFS_TEMP_HI    = 4'h6;
    localparam logic [3:0] OFS_TEMP_LO    = 4'h7;
    localparam logic [3:0] OFS_RES_Y      = 4'h8;
    localparam logic [3:0] OFS_RES_X      = 4'h9;
    localparam logic [3:0] OFS_RES_P1     = 4'ha;
    localparam logic [3:0] OFS_RES_P2     = 4'hb;
    localparam logic [3:0] OFS_RES_AUX    = 4'hc;
    localparam logic [3:0] OFS_RES_TEMP   = 4'hd;
    localparam logic [3:0] OFS_IDENT      = 4'he;

    // sequence_and_alert_config field positions
    localparam int BIT_TEMP_MASK  = 15;
    localparam int BIT_AUX_MASK   = 14;
    localparam int BIT_LIMIT_MODE = 13;
    localparam int BIT_GPIO_MASK  = 12;
    localparam int BIT_AUX_LOW    = 11;
    localparam int BIT_AUX_HIGH   = 10;
    localparam int BIT_TEMP_LOW   = 9;
    localparam int BIT_TEMP_HIGH  = 8;
    localparam int BIT_SEL_Y      = 7;
    localparam int BIT_SEL_AUX    = 3;
    localparam int BIT_SEL_BAT    = 2;
    localparam int BIT_SEL_TEMP   = 1;

    // host-writable bits of the config register: masks, mode, selects
    localparam logic [15:0] SEQ_CFG_WR_MASK = 16'hf0fe;
    localparam logic [15:0] REG_RESET       = 16'h0000;
    // identity field: bits [15:12] unused, read as zero
    localparam logic [15:0] IDENT_MASK      = 16'h0fff;

    // channel codes as the sequencer presents them
    localparam logic [2:0] CH_Y    = 3'h0;
    localparam logic [2:0] CH_X    = 3'h1;
    localparam logic [2:0] CH_P1   = 3'h2;
    localparam logic [2:0] CH_P2   = 3'h3;
    localparam logic [2:0] CH_AUX  = 3'h4;
    localparam logic [2:0] CH_BAT  = 3'h5;
    localparam logic [2:0] CH_TEMP = 3'h6;

    // first conversion delay: 128 us per step
    localparam int CLK_PERIOD_NS  = 50;
    localparam int FCD_STEP_NS    = 128000;
    localparam int FCD_STEP_CYC   = (FCD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W          = 16;

    typedef enum logic [1:0] {
        TASCR_IDLE   = 2'b00,
        TASCR_SETTLE = 2'b01,
        TASCR_GO     = 2'b10
    } tascr_dly_t;
endpackage

// ===== hw/tascr_limit_cmp.sv
// tascr_limit_cmp: compares one result against its high and low limit.
// assumes limits and result are unsigned 16-bit codes.
module tascr_limit_cmp (
    input  wire logic [15:0] result,
    input  wire logic [15:0] high_limit,
    input  wire logic [15:0] low_limit,
    output logic             below_low,
    output logic             above_high
);
    // strict comparisons: equal to a limit is no violation
    assign below_low  = result < low_limit;
    assign above_high = result > high_limit;
endmodule // tascr_limit_cmp

// ===== hw/tascr_regs.sv
// tascr_regs: sequence/alert config, limits, results and identity of the
// touch converter, plus channel selection, settle delay and alert pin.
// assumes a simple word register port fed by the serial host decoder,
// and a conversion engine that reports results with a channel code.

module tascr_regs #(
    parameter int FCD_STEP_CYCLES = tascr_pkg::FCD_STEP_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // host register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata_ff,
    output logic             reg_rvalid_ff,
    // controls held in other registers of the device
    input  wire logic        pen_ind_disable,
    input  wire logic        gpio_enable,
    input  wire logic [3:0]  first_conv_delay,
    // conversion engine side
    input  wire logic        conv_req,
    input  wire logic [2:0]  conv_chan,
    input  wire logic        conv_first,
    output logic             conv_go_ff,
    output logic             settling_ff,
    output logic      [6:0]  seq_channels_ff,
    output logic             aux_pin_gpio_ff,
    input  wire logic        res_wr,
    input  wire logic [2:0]  res_chan,
    input  wire logic [15:0] res_data,
    input  wire logic        seq_done,
    // touch and gpio events
    input  wire logic        touch_active,
    input  wire logic        gpio_event,
    output logic             alert_n_ff
);
    // arbitrary identity value, not that of any real part
    localparam logic [15:0] IDENT_VALUE = 16'h0a5c;

    // config, limit and result storage
    logic [15:0] seq_cfg_ff;
    logic [15:0] aux_hi_ff;
    logic [15:0] aux_lo_ff;
    logic [15:0] temp_hi_ff;
    logic [15:0] temp_lo_ff;
    logic [15:0] res_y_ff;
    logic [15:0] res_x_ff;
    logic [15:0] res_p1_ff;
    logic [15:0] res_p2_ff;
    logic [15:0] res_aux_ff;
    logic [15:0] res_temp_ff;

    // pin-side flags and settle counter
    logic        data_avail_ff;
    logic        gpio_pend_ff;
    logic [tascr_pkg::DLY_W-1:0] dly_cnt_ff;
    tascr_pkg::tascr_dly_t       dly_state_ff;

    // comparator outputs and decoded strobes
    logic        aux_below;
    logic        aux_above;
    logic        temp_below;
    logic        temp_above;
    logic        wr_cfg;
    logic        rd_cfg;
    logic        rd_result;
    logic        aux_res_wr;
    logic        temp_res_wr;

    // combinational next values
    logic [tascr_pkg::DLY_W-1:0] nxt_dly_load;
    logic [15:0] nxt_rdata;
    logic [3:0]  nxt_status;
    logic        nxt_alert_n;
    logic        limit_hit;
    logic [6:0]  nxt_channels;

    assign wr_cfg      = reg_wr && (reg_addr == tascr_pkg::OFS_SEQ_CFG);
    assign rd_cfg      = reg_rd && (reg_addr == tascr_pkg::OFS_SEQ_CFG);
    assign rd_result   = reg_rd && (reg_addr >= tascr_pkg::OFS_RES_Y)
                                && (reg_addr <= tascr_pkg::OFS_RES_TEMP);
    // aux and battery share one result register
    assign aux_res_wr  = res_wr && ((res_chan == tascr_pkg::CH_AUX)
                                 || (res_chan == tascr_pkg::CH_BAT));
    assign temp_res_wr = res_wr && (res_chan == tascr_pkg::CH_TEMP);

    // compare incoming aux/battery result against its limits
    tascr_limit_cmp u_aux_cmp (
        .result     (res_data),
        .high_limit (aux_hi_ff),
        .low_limit  (aux_lo_ff),
        .below_low  (aux_below),
        .above_high (aux_above)
    );

    // compare incoming temperature result against its limits
    tascr_limit_cmp u_temp_cmp (
        .result     (res_data),
        .high_limit (temp_hi_ff),
        .low_limit  (temp_lo_ff),
        .below_low  (temp_below),
        .above_high (temp_above)
    );

    // config: writable masks/mode/selects, sticky status cleared on read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_cfg_ff <= tascr_pkg::REG_RESET;
        end else begin
            if (wr_cfg) begin
                seq_cfg_ff[15:12] <= reg_wdata[15:12];
                seq_cfg_ff[7:1]   <= reg_wdata[7:1];
            end
            // bit 0 is unused and always reads zero
            seq_cfg_ff[0] <= 1'b0;
            seq_cfg_ff[tascr_pkg::BIT_AUX_LOW:tascr_pkg::BIT_TEMP_HIGH] <= nxt_status;
        end
    end

    // sticky limit status: a new violation beats the clear by a config read
    always_comb begin
        nxt_status = seq_cfg_ff[tascr_pkg::BIT_AUX_LOW:tascr_pkg::BIT_TEMP_HIGH];
        if (rd_cfg) begin
            nxt_status = 4'h0;
        end
        if (aux_res_wr && aux_below) begin
            nxt_status[3] = 1'b1;
        end
        if (aux_res_wr && aux_above) begin
            nxt_status[2] = 1'b1;
        end
        if (temp_res_wr && temp_below) begin
            nxt_status[1] = 1'b1;
        end
        if (temp_res_wr && temp_above) begin
            nxt_status[0] = 1'b1;
        end
    end

    // limit registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_hi_ff  <= tascr_pkg::REG_RESET;
            aux_lo_ff  <= tascr_pkg::REG_RESET;
            temp_hi_ff <= tascr_pkg::REG_RESET;
            temp_lo_ff <= tascr_pkg::REG_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                tascr_pkg::OFS_AUX_HI:  aux_hi_ff  <= reg_wdata;
                tascr_pkg::OFS_AUX_LO:  aux_lo_ff  <= reg_wdata;
                tascr_pkg::OFS_TEMP_HI: temp_hi_ff <= reg_wdata;
                tascr_pkg::OFS_TEMP_LO: temp_lo_ff <= reg_wdata;
                default: ;
            endcase
        end
    end

    // result registers, loaded by the conversion engine only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_y_ff    <= tascr_pkg::REG_RESET;
            res_x_ff    <= tascr_pkg::REG_RESET;
            res_p1_ff   <= tascr_pkg::REG_RESET;
            res_p2_ff   <= tascr_pkg::REG_RESET;
            res_aux_ff  <= tascr_pkg::REG_RESET;
            res_temp_ff <= tascr_pkg::REG_RESET;
        end else if (res_wr) begin
            case (res_chan)
                tascr_pkg::CH_Y:    res_y_ff    <= res_data;
                tascr_pkg::CH_X:    res_x_ff    <= res_data;
                tascr_pkg::CH_P1:   res_p1_ff   <= res_data;
                tascr_pkg::CH_P2:   res_p2_ff   <= res_data;
                tascr_pkg::CH_AUX,
                tascr_pkg::CH_BAT:  res_aux_ff  <= res_data;
                tascr_pkg::CH_TEMP: res_temp_ff <= res_data;
                default: ;
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        case (reg_addr)
            tascr_pkg::OFS_SEQ_CFG:  nxt_rdata = seq_cfg_ff;
            tascr_pkg::OFS_AUX_HI:   nxt_rdata = aux_hi_ff;
            tascr_pkg::OFS_AUX_LO:   nxt_rdata = aux_lo_ff;
            tascr_pkg::OFS_TEMP_HI:  nxt_rdata = temp_hi_ff;
            tascr_pkg::OFS_TEMP_LO:  nxt_rdata = temp_lo_ff;
            // results from the conversion engine
            tascr_pkg::OFS_RES_Y:    nxt_rdata = res_y_ff;
            tascr_pkg::OFS_RES_X:    nxt_rdata = res_x_ff;
            tascr_pkg::OFS_RES_P1:   nxt_rdata = res_p1_ff;
            tascr_pkg::OFS_RES_P2:   nxt_rdata = res_p2_ff;
            tascr_pkg::OFS_RES_AUX:  nxt_rdata = res_aux_ff;
            tascr_pkg::OFS_RES_TEMP: nxt_rdata = res_temp_ff;
            tascr_pkg::OFS_IDENT:    nxt_rdata = IDENT_VALUE & tascr_pkg::IDENT_MASK;
            default:                 nxt_rdata = 16'h0000;
        endcase
    end

    // read data register, valid one cycle after the read strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff  <= 16'h0000;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    // effective channel list after aux/battery arbitration
    always_comb begin
        nxt_channels = seq_cfg_ff[7:1];
        // gpio use of the shared pin drops both analog channels
        if (gpio_enable) begin
            nxt_channels[tascr_pkg::BIT_SEL_AUX - 1] = 1'b0;
            nxt_channels[tascr_pkg::BIT_SEL_BAT - 1] = 1'b0;
        end else if (seq_cfg_ff[tascr_pkg::BIT_SEL_BAT]) begin
            nxt_channels[tascr_pkg::BIT_SEL_AUX - 1] = 1'b0;
        end
    end

    // channel list and shared pin function to the sequencer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_channels_ff <= 7'h00;
            aux_pin_gpio_ff <= 1'b0;
        end else begin
            seq_channels_ff <= nxt_channels;
            aux_pin_gpio_ff <= gpio_enable;
        end
    end

    // settle time: (code + 1) steps of 128 us
    assign nxt_dly_load = tascr_pkg::DLY_W'(({12'h000, first_conv_delay} + 16'h0001)
                                            * FCD_STEP_CYCLES);

    // first conversion delay ahead of touch channels and first conversion
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_state_ff <= tascr_pkg::TASCR_IDLE;
            dly_cnt_ff   <= '0;
            conv_go_ff   <= 1'b0;
            settling_ff  <= 1'b0;
        end else begin
            conv_go_ff <= 1'b0;
            case (dly_state_ff)
                tascr_pkg::TASCR_IDLE: begin
                    // touch channels and the first conversion wait to settle
                    if (conv_req) begin
                        if (conv_first || (conv_chan <= tascr_pkg::CH_P2)) begin
                            dly_cnt_ff   <= nxt_dly_load;
                            settling_ff  <= 1'b1;
                            dly_state_ff <= tascr_pkg::TASCR_SETTLE;
                        end else begin
                            dly_state_ff <= tascr_pkg::TASCR_GO;
                        end
                    end
                end
                tascr_pkg::TASCR_SETTLE: begin
                    // last step reached: hand over to the start pulse
                    if (dly_cnt_ff <= 16'h0001) begin
                        settling_ff  <= 1'b0;
                        dly_state_ff <= tascr_pkg::TASCR_GO;
                    end else begin
                        dly_cnt_ff <= dly_cnt_ff - 16'h0001;
                    end
                end
                tascr_pkg::TASCR_GO: begin
                    // one-cycle start pulse, then back to idle
                    conv_go_ff   <= 1'b1;
                    dly_state_ff <= tascr_pkg::TASCR_IDLE;
                end
                default: dly_state_ff <= tascr_pkg::TASCR_IDLE;
            endcase
        end
    end

    // data available: set at end of sequence, cleared by a result read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_avail_ff <= 1'b0;
        end else begin
            data_avail_ff <= seq_done || (data_avail_ff && !rd_result);
        end
    end

    // gpio alert pending: sticky, cleared on config read, set wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_pend_ff <= 1'b0;
        end else begin
            gpio_pend_ff <= gpio_event || (gpio_pend_ff && !rd_cfg);
        end
    end

    // unmasked limit sources
    assign limit_hit =
        (!seq_cfg_ff[tascr_pkg::BIT_TEMP_MASK]
            && (seq_cfg_ff[tascr_pkg::BIT_TEMP_LOW] || seq_cfg_ff[tascr_pkg::BIT_TEMP_HIGH]))
        || (!seq_cfg_ff[tascr_pkg::BIT_AUX_MASK]
            && (seq_cfg_ff[tascr_pkg::BIT_AUX_LOW] || seq_cfg_ff[tascr_pkg::BIT_AUX_HIGH]))
        || (!seq_cfg_ff[tascr_pkg::BIT_GPIO_MASK] && gpio_pend_ff);

    // shared output: pen indicator, data available, or limit alert
    always_comb begin
        if (!pen_ind_disable) begin
            nxt_alert_n = !touch_active;
        end else if (!seq_cfg_ff[tascr_pkg::BIT_LIMIT_MODE]) begin
            nxt_alert_n = !data_avail_ff;
        end else begin
            nxt_alert_n = !limit_hit;
        end
    end

    // registered pin drive, idle high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_n_ff <= 1'b1;
        end else begin
            alert_n_ff <= nxt_alert_n;
        end
    end
endmodule // tascr_regs

// ===== dv/tascr_regs_props.sv
// tascr_regs_props: port assertions and covers for the register bank.
// assumes it is bound onto tascr_regs and shares its clock and reset.
module tascr_regs_props #(
    parameter int FCD_STEP_CYCLES = 4
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata_ff,
    input wire logic        reg_rvalid_ff,
    input wire logic        pen_ind_disable,
    input wire logic        conv_req,
    input wire logic [2:0]  conv_chan,
    input wire logic        conv_first,
    input wire logic        conv_go_ff,
    input wire logic        settling_ff,
    input wire logic [6:0]  seq_channels_ff,
    input wire logic        aux_pin_gpio_ff,
    input wire logic        touch_active,
    input wire logic        alert_n_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // engine idle: no settle and no start pulse under way
    logic idle;
    assign idle = !settling_ff && !conv_go_ff;
    // register port
    AST_RVALID: assert property (reg_rvalid_ff == $past(reg_rd))
        else $error("read valid does not follow the read strobe");
    AST_ID_TOP: assert property (reg_rd && reg_addr == tascr_pkg::OFS_IDENT
        |=> reg_rdata_ff[15:12] == 4'h0) else $error("identity top bits not zero");
    AST_LIM_RB: assert property (reg_wr && reg_addr == 4'h7 ##2 reg_rd && reg_addr == 4'h7
        |=> reg_rdata_ff == $past(reg_wdata, 3)) else $error("limit readback differs");
    // channel selection
    AST_GPIO_SKIP: assert property (aux_pin_gpio_ff |-> seq_channels_ff[2:1] == 2'b00)
        else $error("aux or battery selected with gpio on");
    AST_BAT_ONLY: assert property (seq_channels_ff[1] |-> !seq_channels_ff[2])
        else $error("aux and battery both selected");
    // conversion start and settle
    AST_GO_FAST: assert property (conv_req && idle && conv_chan inside {[4:6]} && !conv_first
        |-> ##1 !conv_go_ff ##1 conv_go_ff) else $error("fast start not two cycles");
    AST_SETTLE_ON: assert property (conv_req && idle && (conv_chan < 3'h4 || conv_first)
        |=> settling_ff [*2]) else $error("settle delay missing");
    AST_SETTLE_GO: assert property ($fell(settling_ff) |-> ##[0:1] conv_go_ff)
        else $error("no start after settle");
    AST_GO_PULSE: assert property (conv_go_ff |=> !conv_go_ff)
        else $error("start pulse longer than one cycle");
    // pen indication
    AST_PEN: assert property (!pen_ind_disable |=> alert_n_ff == !$past(touch_active))
        else $error("pen output does not follow touch");
    // main scenarios
    cover property (conv_go_ff && $past(settling_ff, 2));
    cover property ($fell(alert_n_ff) && pen_ind_disable);
    cover property (aux_pin_gpio_ff && reg_rvalid_ff);
endmodule // tascr_regs_props

bind tascr_regs tascr_regs_props #(.FCD_STEP_CYCLES(FCD_STEP_CYCLES)) i_props (.*);

// ===== dv/tascr_host.sv
// tascr_host: host model driving the word register port.
// assumes tasks are entered just after a falling clock edge.
module tascr_host (
    input  wire logic        core_clk,
    output logic      [3:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one write cycle; released lines show inverted junk
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
        @(negedge core_clk); // let an edge pass before the next transfer
    endtask
    // one read cycle; data taken the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        v = reg_rdata_ff;
        @(negedge core_clk); // let an edge pass before the next transfer
    endtask
endmodule // tascr_host

// ===== dv/tascr_regs_bench.sv
// tascr_regs_bench: self-checking bench for the sequence/limit register bank.
// assumes tascr_host on the register port and a 20 MHz core clock.
module tascr_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 4;
    logic core_clk = 1'b0, rst_n = 1'b0, pen_ind_disable = 1'b1, gpio_enable = 1'b0;
    logic conv_req = 1'b0, conv_first = 1'b0, res_wr = 1'b0, seq_done = 1'b0;
    logic touch_active = 1'b0, gpio_event = 1'b0, reg_wr, reg_rd, reg_rvalid_ff;
    logic conv_go_ff, settling_ff, aux_pin_gpio_ff, alert_n_ff;
    logic [3:0]  first_conv_delay = 4'h0, reg_addr;
    logic [2:0]  conv_chan = 3'h0, res_chan = 3'h0;
    logic [15:0] res_data = 16'h0000, reg_wdata, reg_rdata_ff, d, c;
    logic [6:0]  seq_channels_ff;
    logic [31:0] rnd = 32'hf893;
    int          err_count = 0, comparisons = 0;
    // alert table: config, source (7 = gpio), expected pin
    logic [15:0] tcfg [8] = '{16'hf000, 16'h6000, 16'ha000, 16'ha000, 16'h6000,
                              16'h2000, 16'h3000, 16'h0000};
    logic [2:0]  tch  [8] = '{3'h6, 3'h6, 3'h6, 3'h4, 3'h4, 3'h7, 3'h7, 3'h6};
    logic        texp [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    // limit table: channel, result, expected status bits
    logic [2:0]  fch  [6] = '{3'h4, 3'h4, 3'h6, 3'h6, 3'h4, 3'h6};
    logic [15:0] fdat [6] = '{16'h0101, 16'h004f, 16'h0201, 16'h007f, 16'h0100, 16'h0080};
    logic [15:0] fexp [6] = '{16'h0400, 16'h0800, 16'h0100, 16'h0200, 16'h0000, 16'h0000};
    tascr_regs #(.FCD_STEP_CYCLES(STEP)) i_dut (.*);
    tascr_host i_host (.*);
    // clock
    always #25 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // channels the sequencer should really convert
    function automatic logic [6:0] exp_seq(input logic [15:0] v, input logic g);
        logic [6:0] s;
        s = v[7:1];
        if (g) s[2:1] = 2'b00;
        else if (s[2] && s[1]) s[2] = 1'b0;
        return s;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic res(input logic [2:0] ch, input logic [15:0] v);
        res_chan = ch;
        res_data = v;
        res_wr = 1'b1;
        @(negedge core_clk);
        res_wr = 1'b0;
    endtask
    // one conversion request, cycles counted up to the start pulse
    task automatic go(input logic [2:0] ch, input logic f, input int exp);
        int n;
        conv_chan = ch;
        conv_first = f;
        conv_req = 1'b1;
        @(negedge core_clk);
        conv_req = 1'b0;
        conv_first = 1'b0;
        n = 1;
        while (conv_go_ff !== 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        @(negedge core_clk);
        chk(16'(n), 16'(exp));
    endtask
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // watchdog
    initial begin
        #500000;
        err_count++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        for (int a = 0; a < 14; a++) begin
            i_host.rd(a[3:0], d);
            chk(d, 16'h0000);
        end
        i_host.rd(4'hf, d);
        chk(d, 16'h0000);
        i_host.rd(4'he, c);
        chk(c & ~tascr_pkg::IDENT_MASK, 16'h0000);
        i_host.wr(4'he, ~c);
        i_host.rd(4'he, d);
        chk(d, c);
        i_host.wr(4'h8, 16'hbeef);
        i_host.rd(4'h8, d);
        chk(d, 16'h0000);
        for (int a = 4; a < 8; a++) begin
            rnd = lfsr(rnd);
            i_host.wr(a[3:0], rnd[15:0]);
            i_host.rd(a[3:0], d);
            chk(d, rnd[15:0]);
        end
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            c = (i == 0) ? 16'hffff : (rnd[15:0] | ((i == 1) ? 16'h000c : 16'h0000));
            gpio_enable = (i < 2) ? (i == 0) : rnd[16];
            i_host.wr(4'h3, c);
            repeat (2) @(negedge core_clk);
            i_host.rd(4'h3, d);
            chk(d, c & tascr_pkg::SEQ_CFG_WR_MASK);
            chk({9'h000, seq_channels_ff}, {9'h000, exp_seq(c, gpio_enable)});
            chk({15'h0000, aux_pin_gpio_ff}, {15'h0000, gpio_enable});
        end
        gpio_enable = 1'b0;
        i_host.wr(4'h4, 16'h0100);
        i_host.wr(4'h5, 16'h0050);
        i_host.wr(4'h6, 16'h0200);
        i_host.wr(4'h7, 16'h0080);
        for (int i = 0; i < 6; i++) begin
            res(fch[i], fdat[i]);
            i_host.rd(4'h3, d);
            chk(d & 16'h0f00, fexp[i]);
        end
        for (int i = 0; i < 8; i++) begin
            i_host.wr(4'h3, tcfg[i]);
            if (tch[i] == 3'h7) begin
                gpio_event = 1'b1;
                @(negedge core_clk);
                gpio_event = 1'b0;
            end else res(tch[i], (tch[i] == 3'h6) ? 16'h0201 : 16'h0101);
            repeat (2) @(negedge core_clk);
            chk({15'h0000, alert_n_ff}, {15'h0000, texp[i]});
            i_host.rd(4'h3, d);
            repeat (2) @(negedge core_clk);
        end
        seq_done = 1'b1;
        @(negedge core_clk);
        seq_done = 1'b0;
        repeat (2) @(negedge core_clk);
        chk({15'h0000, alert_n_ff}, 16'h0000);
        i_host.rd(4'h9, d);
        repeat (2) @(negedge core_clk);
        chk({15'h0000, alert_n_ff}, 16'h0001);
        pen_ind_disable = 1'b0;
        touch_active = 1'b1;
        repeat (2) @(negedge core_clk);
        chk({15'h0000, alert_n_ff}, 16'h0000);
        touch_active = 1'b0;
        repeat (2) @(negedge core_clk);
        chk({15'h0000, alert_n_ff}, 16'h0001);
        for (int ch = 0; ch < 7; ch++) begin
            rnd = lfsr(rnd);
            res(ch[2:0], rnd[15:0]);
            i_host.rd((ch < 5) ? 4'h8 + ch[3:0] : ((ch == 5) ? 4'hc : 4'hd), d);
            chk(d, rnd[15:0]);
        end
        go(3'h4, 1'b0, 2);
        go(3'h6, 1'b0, 2);
        for (int ch = 0; ch < 4; ch++) begin
            rnd = lfsr(rnd);
            first_conv_delay = (ch == 0) ? 4'hf : rnd[3:0];
            go(ch[2:0], 1'b0, (int'(first_conv_delay) + 1) * STEP + 2);
        end
        first_conv_delay = 4'h0;
        go(3'h5, 1'b1, STEP + 2);
        finish_test();
    end
endmodule // tascr_regs_bench
